// ==== core/ssra_map.svh ====
`ifndef SSRA_MAP_SVH
`define SSRA_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets (lower byte of each word)
// ----------------------------------------------------------------
`define SSRA_OFS_FLASH_WRITE_COUNT 7'h00
`define SSRA_OFS_ACCEL_OFFSET_TRIM 7'h02
`define SSRA_OFS_AUX1_OFFSET_TRIM 7'h04
`define SSRA_OFS_AUX2_OFFSET_TRIM 7'h06
`define SSRA_OFS_SUPPLY_LEVEL_CAPTURED 7'h0A
`define SSRA_OFS_TEMPERATURE_CAPTURED 7'h0C
`define SSRA_OFS_ACCEL_PEAK_VALUE 7'h0E
`define SSRA_OFS_AUX1_PEAK_VALUE 7'h10
`define SSRA_OFS_AUX2_PEAK_VALUE 7'h12
`define SSRA_OFS_ACCEL_SAMPLE_WINDOW 7'h14
`define SSRA_OFS_AUX1_SAMPLE_WINDOW 7'h16
`define SSRA_OFS_AUX2_SAMPLE_WINDOW 7'h18
`define SSRA_OFS_SAMPLE_INDEX_POINTER 7'h1A
`define SSRA_OFS_ACQUISITION_CONTROL 7'h1C
`define SSRA_OFS_ACQUISITION_PERIOD 7'h1E
`define SSRA_OFS_ACCEL_ALARM_THRESHOLD 7'h20
`define SSRA_OFS_AUX1_ALARM_THRESHOLD 7'h22
`define SSRA_OFS_AUX2_ALARM_THRESHOLD 7'h24
`define SSRA_OFS_SYSTEM_ALARM_THRESHOLD 7'h26
`define SSRA_OFS_ALARM_CONFIGURATION 7'h28
`define SSRA_OFS_GENERAL_IO_CONTROL 7'h32
`define SSRA_OFS_SELFTEST_INPUT_CONFIG 7'h34
`define SSRA_OFS_DIGITAL_LINE_CONFIG 7'h36
`define SSRA_OFS_FILTER_CONFIGURATION 7'h38
`define SSRA_OFS_SYSTEM_STATUS 7'h3C
`define SSRA_OFS_GLOBAL_COMMAND 7'h3E
`define SSRA_OFS_SELFTEST_RESPONSE 7'h40
`define SSRA_OFS_LOT_CODE_LOW 7'h52
`define SSRA_OFS_LOT_CODE_HIGH 7'h54
`define SSRA_OFS_PRODUCT_IDENTIFIER 7'h56
`define SSRA_OFS_UNIT_SERIAL_NUMBER 7'h58
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSRA_RST_ZERO 16'h0000
`define SSRA_RST_RESULT 16'h8000
`define SSRA_RST_ACQ_CTRL 16'h0020
`define SSRA_RST_SELFTEST 16'h0003
`define SSRA_RST_DIO 16'h000F
// arbitrary neutral identity value
`define SSRA_RST_PRODUCT_ID 16'h5A5A
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSRA_CMD_CAPTURE_BIT 11
`define SSRA_CMD_STORE_BIT 12
`define SSRA_PTR_MSB 9
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSRA_SYS_CLK_PS 40000
`define SSRA_SYS_CLK_KHZ 25000
`define SSRA_SCLK_MAX_KHZ 2250
`define SSRA_T_CS_PS 48800
`define SSRA_T_STALL_PS 15400000
`define SSRA_HALF_CYC ((`SSRA_SYS_CLK_KHZ + 2 * `SSRA_SCLK_MAX_KHZ - 1) \
  / (2 * `SSRA_SCLK_MAX_KHZ))
`define SSRA_CS_CYC ((`SSRA_T_CS_PS + `SSRA_SYS_CLK_PS - 1) \
  / `SSRA_SYS_CLK_PS)
`define SSRA_STALL_CYC ((`SSRA_T_STALL_PS + `SSRA_SYS_CLK_PS - 1) \
  / `SSRA_SYS_CLK_PS)
`endif

// ==== core/ssra_pkg.sv ====
`include "ssra_map.svh"
package ssra_pkg;
  // ----------------------------------------------------------------
  // frame and register attribute types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } ssra_frame_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic flash;
    logic [15:0] rst;
  } ssra_attr_s;

  typedef enum logic {SSRA_LOAD, SSRA_RUN} ssra_dev_state_e;
  typedef enum logic [2:0] {
    SSRA_IDLE, SSRA_SETUP, SSRA_SHIFT, SSRA_HOLD, SSRA_STALL
  } ssra_host_state_e;

  // word index of a byte address
  function automatic logic [5:0] widx(logic [6:0] a);
    return a[6:1];
  endfunction : widx

  // access, backup and reset value of the word holding a byte address
  function automatic ssra_attr_s reg_attr(logic [6:0] a);
    ssra_attr_s r;
    r = '0;
    case ({a[6:1], 1'b0})
      `SSRA_OFS_FLASH_WRITE_COUNT, `SSRA_OFS_SYSTEM_STATUS,
      `SSRA_OFS_SELFTEST_RESPONSE, `SSRA_OFS_LOT_CODE_LOW,
      `SSRA_OFS_LOT_CODE_HIGH, `SSRA_OFS_UNIT_SERIAL_NUMBER:
        r = '{1'b1, 1'b0, 1'b1, `SSRA_RST_ZERO};
      `SSRA_OFS_ACCEL_OFFSET_TRIM, `SSRA_OFS_AUX1_OFFSET_TRIM,
      `SSRA_OFS_AUX2_OFFSET_TRIM, `SSRA_OFS_ACQUISITION_PERIOD,
      `SSRA_OFS_ACCEL_ALARM_THRESHOLD, `SSRA_OFS_AUX1_ALARM_THRESHOLD,
      `SSRA_OFS_AUX2_ALARM_THRESHOLD, `SSRA_OFS_SYSTEM_ALARM_THRESHOLD,
      `SSRA_OFS_ALARM_CONFIGURATION, `SSRA_OFS_GENERAL_IO_CONTROL,
      `SSRA_OFS_FILTER_CONFIGURATION:
        r = '{1'b1, 1'b1, 1'b1, `SSRA_RST_ZERO};
      `SSRA_OFS_SUPPLY_LEVEL_CAPTURED, `SSRA_OFS_TEMPERATURE_CAPTURED,
      `SSRA_OFS_ACCEL_PEAK_VALUE, `SSRA_OFS_AUX1_PEAK_VALUE,
      `SSRA_OFS_AUX2_PEAK_VALUE:
        r = '{1'b1, 1'b0, 1'b1, `SSRA_RST_RESULT};
      `SSRA_OFS_ACCEL_SAMPLE_WINDOW, `SSRA_OFS_AUX1_SAMPLE_WINDOW,
      `SSRA_OFS_AUX2_SAMPLE_WINDOW:
        r = '{1'b1, 1'b0, 1'b0, `SSRA_RST_RESULT};
      `SSRA_OFS_SAMPLE_INDEX_POINTER:
        r = '{1'b1, 1'b1, 1'b0, `SSRA_RST_ZERO};
      `SSRA_OFS_ACQUISITION_CONTROL:
        r = '{1'b1, 1'b1, 1'b1, `SSRA_RST_ACQ_CTRL};
      `SSRA_OFS_SELFTEST_INPUT_CONFIG:
        r = '{1'b1, 1'b1, 1'b1, `SSRA_RST_SELFTEST};
      `SSRA_OFS_DIGITAL_LINE_CONFIG:
        r = '{1'b1, 1'b1, 1'b1, `SSRA_RST_DIO};
      `SSRA_OFS_PRODUCT_IDENTIFIER:
        r = '{1'b1, 1'b0, 1'b1, `SSRA_RST_PRODUCT_ID};
      `SSRA_OFS_GLOBAL_COMMAND:
        r = '{1'b0, 1'b1, 1'b0, `SSRA_RST_ZERO};
      default:
        r = '0;
    endcase
    return r;
  endfunction : reg_attr
endpackage : ssra_pkg

// ==== core/ssra_link_if.sv ====
`timescale 1ns/10ps
interface ssra_link_if;
  logic sclk;
  logic cs_b;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // line level at the master; pulled high while released
  assign miso = miso_oe ? miso_o : 1'b1;
  modport device (
    input sclk,
    input cs_b,
    input mosi,
    output miso_o,
    output miso_oe
  );
  modport host (
    output sclk,
    output cs_b,
    output mosi,
    input miso
  );
endinterface : ssra_link_if

// ==== core/ssra_host.sv ====
`timescale 1ns/10ps
`include "ssra_map.svh"
module ssra_host (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  ssra_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  // ----------------------------------------------------------------
  // master state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssra_pkg::ssra_host_state_e st;
    logic [8:0] div;
    logic [4:0] bits;
    logic [15:0] tx;
    logic [15:0] rx;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic rsp_v;
    logic [15:0] rsp;
    logic [1:0] ms;
  } ssra_host_s;

  ssra_host_s h_q;
  ssra_host_s h_d;

  // frame sequencer: mode 3, msb first, clock divided from sys_clk
  always_comb
  begin
    h_d = h_q;
    if (clk_en)
    begin
      h_d.rsp_v = 1'b0;
      h_d.ms = {h_q.ms[0], link.miso};
      h_d.div = h_q.div + 9'd1;
      case (h_q.st)
        ssra_pkg::SSRA_IDLE:
        begin
          h_d.div = '0;
          if (cmd_valid)
          begin
            h_d.tx = {cmd_write, cmd_addr, cmd_data};
            h_d.mosi = cmd_write;
            h_d.cs_b = 1'b0;
            h_d.bits = '0;
            h_d.st = ssra_pkg::SSRA_SETUP;
          end
        end
        ssra_pkg::SSRA_SETUP:
          if (h_q.div == 9'(`SSRA_CS_CYC - 1))
          begin
            h_d.div = '0;
            h_d.st = ssra_pkg::SSRA_SHIFT;
          end
        ssra_pkg::SSRA_SHIFT:
          if (h_q.div == 9'(`SSRA_HALF_CYC - 1))
          begin
            h_d.div = '0;
            h_d.sclk = ~h_q.sclk;
            if (h_q.sclk)
            begin
              // falling edge: next bit out, first bit already set
              if (h_q.bits != 5'd0)
              begin
                h_d.tx = {h_q.tx[14:0], 1'b0};
                h_d.mosi = h_q.tx[14];
              end
            end
            else
            begin
              // rising edge: reply bit in, full duplex
              h_d.rx = {h_q.rx[14:0], h_q.ms[1]};
              h_d.bits = h_q.bits + 5'd1;
              if (h_q.bits == 5'd15)
                h_d.st = ssra_pkg::SSRA_HOLD;
            end
          end
        ssra_pkg::SSRA_HOLD:
          if (h_q.div == 9'(`SSRA_CS_CYC - 1))
          begin
            h_d.cs_b = 1'b1;
            h_d.rsp_v = 1'b1;
            h_d.rsp = h_q.rx;
            h_d.div = '0;
            h_d.st = ssra_pkg::SSRA_STALL;
          end
        ssra_pkg::SSRA_STALL:
          if (h_q.div == 9'(`SSRA_STALL_CYC - 1))
            h_d.st = ssra_pkg::SSRA_IDLE;
        default:
          h_d.st = ssra_pkg::SSRA_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      h_q <= '0;
      h_q.st <= ssra_pkg::SSRA_IDLE;
      h_q.sclk <= 1'b1;
      h_q.cs_b <= 1'b1;
    end
    else
      h_q <= h_d;
  end

  // outputs
  assign cmd_ready = (h_q.st == ssra_pkg::SSRA_IDLE);
  assign rsp_valid = h_q.rsp_v;
  assign rsp_data = h_q.rsp;
  assign link.sclk = h_q.sclk;
  assign link.cs_b = h_q.cs_b;
  assign link.mosi = h_q.mosi;
endmodule : ssra_host

// ==== core/ssra_device.sv ====
// Functional notes
// - every register is a 16-bit two-byte word
// - upper byte address is lower plus one
// - link answers only while select is low
// - output driven while selected, released otherwise
// - input bits sampled on rising clock edges
// - output bits shifted on falling clock edges
// - reply shifts out while request shifts in
// - master uses mode 3, 16-bit msb first
// - master keeps clock at or below 2.25 MHz
// - one write frame updates one byte; a store command frame increments the whole write count word
// - command bit 11 starts manual capture
// - command bit 12 stores backed registers
// - volatile copy governs, backed words saved
// - reset loads backup before running
// - read request: flag clear, address, data ignored
// - master sends cmd_data unchanged as read request data
// - reply comes in next frame, pipelined
// - repeated window reads return window contents
// - unused addresses do nothing, read zero
// - digital lines: busy, alarm, gpio, trigger
`timescale 1ns/10ps
`include "ssra_map.svh"
module ssra_device (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic clk_en,
  ssra_link_if.device link,
  output logic config_ready,
  output logic capture_start,
  output logic flash_store,
  output logic [9:0] sample_index,
  input wire logic result_we,
  input wire logic [6:0] result_addr,
  input wire logic [15:0] result_data,
  input wire logic busy_in,
  input wire logic alarm_in,
  input wire logic [1:0] gp_line_in,
  output logic [1:0] gp_line_out,
  output logic [1:0] gp_line_oe
);
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cnt;
    logic [15:0] sh;
  } ssra_rx_s;

  typedef struct packed {
    logic tog;
    ssra_pkg::ssra_frame_s fr;
  } ssra_ev_s;

  typedef struct packed {
    ssra_pkg::ssra_dev_state_e st;
    logic [63:0][15:0] vol;
    logic [15:0] rd;
    logic [2:0] tog;
    logic [1:0] gs1;
    logic [1:0] gs2;
    logic [1:0] gs3;
    logic cap;
    logic store;
  } ssra_core_s;

  ssra_rx_s rx_q;
  ssra_rx_s rx_d;
  ssra_ev_s ev_q;
  ssra_ev_s ev_d;
  logic [15:0] tx_q;
  ssra_core_s c_q;
  ssra_core_s c_d;
  logic [63:0][15:0] nv_q;
  logic lk_rst_b;

  // ----------------------------------------------------------------
  // link side, clocked by the serial clock
  // ----------------------------------------------------------------
  // bit counter and shifter held in reset while deselected
  assign lk_rst_b = rst_b & ~link.cs_b;

  // input shifting and frame capture
  always_comb
  begin
    rx_d.sh = {rx_q.sh[14:0], link.mosi};
    rx_d.cnt = rx_q.cnt + 4'd1;
    ev_d = ev_q;
    if (rx_q.cnt == 4'd15)
    begin
      ev_d.fr = rx_d.sh;
      ev_d.tog = ~ev_q.tog;
    end
  end

  // shifter state
  always_ff @(posedge link.sclk or negedge lk_rst_b)
  begin
    if (!lk_rst_b)
      rx_q <= '0;
    else
      rx_q <= rx_d;
  end

  // completed frame, kept across deselect for the core
  always_ff @(posedge link.sclk or negedge rst_b)
  begin
    if (!rst_b)
      ev_q <= '0;
    else
      ev_q <= ev_d;
  end

  // reply loads at the first falling edge; core word is static by then
  always_ff @(negedge link.sclk or negedge lk_rst_b)
  begin
    if (!lk_rst_b)
      tx_q <= '0;
    else if (rx_q.cnt == 4'd0)
      tx_q <= c_q.rd;
    else
      tx_q <= {tx_q[14:0], 1'b0};
  end

  assign link.miso_o = tx_q[15];
  assign link.miso_oe = ~link.cs_b;

  // ----------------------------------------------------------------
  // core side, clocked by sys_clk
  // ----------------------------------------------------------------
  // frame decode, register bank, load sequence and line triggers
  always_comb
  begin
    ssra_pkg::ssra_frame_s f;
    ssra_pkg::ssra_attr_s a;
    logic [5:0] w;
    logic [5:0] pw;
    f = ev_q.fr;
    a = ssra_pkg::reg_attr(f.addr);
    w = ssra_pkg::widx(f.addr);
    pw = ssra_pkg::widx(`SSRA_OFS_SAMPLE_INDEX_POINTER);
    c_d = c_q;
    if (clk_en)
    begin
      c_d.cap = 1'b0;
      c_d.store = 1'b0;
      c_d.tog = {c_q.tog[1:0], ev_q.tog};
      c_d.gs1 = gp_line_in;
      c_d.gs2 = c_q.gs1;
      c_d.gs3 = c_q.gs2;
      case (c_q.st)
        ssra_pkg::SSRA_LOAD:
        begin
          for (int i = 0; i < 64; i++)
          begin
            a = ssra_pkg::reg_attr({6'(i), 1'b0});
            c_d.vol[i] = a.flash ? nv_q[i] : a.rst;
          end
          c_d.st = ssra_pkg::SSRA_RUN;
        end
        ssra_pkg::SSRA_RUN:
        begin
          if (result_we)
            c_d.vol[ssra_pkg::widx(result_addr)] = result_data;
          if (c_q.tog[2] ^ c_q.tog[1])
          begin
            if (f.wr)
            begin
              if (f.addr == `SSRA_OFS_GLOBAL_COMMAND + 7'h01)
              begin
                c_d.cap = f.data[`SSRA_CMD_CAPTURE_BIT - 8];
                c_d.store = f.data[`SSRA_CMD_STORE_BIT - 8];
                if (c_d.store)
                  c_d.vol[0] = c_q.vol[0] + 16'h0001;
              end
              else if (a.wr && f.addr[0])
                c_d.vol[w][15:8] = f.data;
              else if (a.wr)
                c_d.vol[w][7:0] = f.data;
            end
            else
            begin
              // data byte of a request is ignored
              c_d.rd = a.rd ? c_q.vol[w] : 16'h0000;
              if (w >= ssra_pkg::widx(`SSRA_OFS_ACCEL_SAMPLE_WINDOW) &&
                  w <= ssra_pkg::widx(`SSRA_OFS_AUX2_SAMPLE_WINDOW))
                c_d.vol[pw][`SSRA_PTR_MSB:0] =
                  c_q.vol[pw][`SSRA_PTR_MSB:0] + 10'd1;
            end
          end
          // trigger-input lines start a capture on a rising edge
          for (int i = 0; i < 2; i++)
            if (c_q.vol[ssra_pkg::widx(`SSRA_OFS_DIGITAL_LINE_CONFIG)]
                [2 * i +: 2] == 2'b11 && c_q.gs2[i] && !c_q.gs3[i])
              c_d.cap = 1'b1;
        end
        default:
          c_d.st = ssra_pkg::SSRA_LOAD;
      endcase
    end
  end

  // core state register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      c_q <= '0;
      c_q.st <= ssra_pkg::SSRA_LOAD;
    end
    else
      c_q <= c_d;
  end

  // nonvolatile copy, survives rst_b, loaded with reset values only at power-on
  always_ff @(posedge sys_clk or negedge por_b)
  begin
    if (!por_b)
    begin
      for (int i = 0; i < 64; i++)
        nv_q[i] <= ssra_pkg::reg_attr({6'(i), 1'b0}).rst;
    end
    else if (clk_en && c_q.store)
    begin
      for (int i = 0; i < 64; i++)
        if (ssra_pkg::reg_attr({6'(i), 1'b0}).flash)
          nv_q[i] <= c_q.vol[i];
    end
  end

  // ----------------------------------------------------------------
  // outputs and digital lines
  // ----------------------------------------------------------------
  assign config_ready = (c_q.st == ssra_pkg::SSRA_RUN);
  assign capture_start = c_q.cap;
  assign flash_store = c_q.store;
  assign sample_index =
    c_q.vol[ssra_pkg::widx(`SSRA_OFS_SAMPLE_INDEX_POINTER)]
    [`SSRA_PTR_MSB:0];

  // per line: 0 busy, 1 alarm, 2 gpio, 3 trigger input
  for (genvar g = 0; g < 2; g++)
  begin : g_line
    logic [1:0] mode;
    logic [15:0] gio;
    assign mode = c_q.vol[ssra_pkg::widx(`SSRA_OFS_DIGITAL_LINE_CONFIG)]
      [2 * g +: 2];
    assign gio = c_q.vol[ssra_pkg::widx(`SSRA_OFS_GENERAL_IO_CONTROL)];
    assign gp_line_out[g] = (mode == 2'b00) ? busy_in :
                            (mode == 2'b01) ? alarm_in : gio[g + 8];
    assign gp_line_oe[g] = (mode == 2'b00) || (mode == 2'b01) ||
                           ((mode == 2'b10) && gio[g]);
  end
endmodule : ssra_device

// ==== sim/ssra_link_chk.sv ====
`timescale 1ns/10ps
module ssra_link_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // ----------------------------------------------------------------
  // link wire checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic sclk_q;
  logic [4:0] rise_q;
  // rising clock edges seen within one frame
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 1'h1;
      rise_q <= 5'h00;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_b)
        rise_q <= 5'h00;
      else if (sclk && !sclk_q)
        rise_q <= rise_q + 5'h01;
    end
  end
  // one half period of the link clock
  sequence s_low;
    (!sclk) [*6] ##1 sclk;
  endsequence
  sequence s_high;
    sclk [*6];
  endsequence
  property p_oe_sel;
    miso_oe == !cs_b;
  endproperty
  property p_idle_high;
    cs_b |-> sclk;
  endproperty
  property p_mosi_fall;
    !cs_b && $past(!cs_b) && $changed(mosi) |-> $fell(sclk);
  endproperty
  property p_miso_fall;
    miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sclk;
  endproperty
  property p_low_half;
    $fell(sclk) |-> s_low;
  endproperty
  property p_high_half;
    $rose(sclk) |-> s_high;
  endproperty
  property p_bits16;
    $rose(cs_b) |-> rise_q == 5'h10;
  endproperty
  property p_setup;
    $fell(cs_b) |-> sclk [*2] ##1 !cs_b;
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("data out enable does not follow select");
  a_idle_high: assert property (p_idle_high)
    else $error("link clock low outside a frame");
  a_mosi_fall: assert property (p_mosi_fall)
    else $error("input data changed off a falling edge");
  a_miso_fall: assert property (p_miso_fall)
    else $error("output data changed while clock high");
  a_low_half: assert property (p_low_half)
    else $error("clock low phase not six cycles");
  a_high_half: assert property (p_high_half)
    else $error("clock high phase too short");
  a_bits16: assert property (p_bits16)
    else $error("frame not sixteen clock rises");
  a_setup: assert property (p_setup)
    else $error("clock edge too soon after select");
endmodule : ssra_link_chk

// ==== sim/ssra_tb_top.sv ====
`timescale 1ns/10ps
`include "ssra_map.svh"
module ssra_tb_top;
  // ----------------------------------------------------------------
  // bench signals and model
  // ----------------------------------------------------------------
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic por_b = 1'h0;
  logic cmd_valid, cmd_write, result_we, busy_in, alarm_in, pend;
  logic cmd_ready, rsp_valid, config_ready, capture_start, flash_store;
  logic [6:0] cmd_addr, result_addr;
  logic [7:0] cmd_data;
  logic [15:0] result_data, rsp_data, pend_v;
  logic [1:0] gp_line_in, gp_line_out, gp_line_oe;
  logic [9:0] sample_index;
  logic [31:0] rs = 32'h28;
  int n_fail, check_count, n_cap, e_cap, n_st, e_st;
  logic [15:0] mdl [64];
  logic [15:0] nv [64];
  always #20 sys_clk = ~sys_clk;
  ssra_link_if link ();
  ssra_host i_ssra_host (.sys_clk, .rst_b, .clk_en(1'h1), .link,
    .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_data,
    .rsp_valid, .rsp_data);
  ssra_device i_ssra_device (.sys_clk, .rst_b, .por_b, .clk_en(1'h1),
    .link, .config_ready, .capture_start, .flash_store, .sample_index,
    .result_we, .result_addr, .result_data, .busy_in, .alarm_in,
    .gp_line_in, .gp_line_out, .gp_line_oe);
  ssra_link_chk i_ssra_link_chk (.sys_clk, .rst_b, .sclk(link.sclk),
    .cs_b(link.cs_b), .mosi(link.mosi), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe));
  // pulse counters
  always @(negedge sys_clk)
  begin
    if (capture_start === 1'h1) n_cap++;
    if (flash_store === 1'h1) n_st++;
  end
  // ----------------------------------------------------------------
  // expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [15:0] rst_val(logic [6:0] a);
    case (a)
      7'h0A, 7'h0C, 7'h0E, 7'h10, 7'h12, 7'h14, 7'h16, 7'h18:
        return 16'h8000;
      7'h1C: return 16'h0020;
      7'h34: return 16'h0003;
      7'h36: return 16'h000F;
      7'h56: return `SSRA_RST_PRODUCT_ID;
      default: return 16'h0000;
    endcase
  endfunction : rst_val
  function automatic logic backed(logic [6:0] a);
    return !(a inside {[7'h14:7'h1B], 7'h3E, 7'h3F});
  endfunction : backed
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic close_out();
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic do_reset(logic p);
    @(negedge sys_clk);
    rst_b = 1'h0;
    por_b = !p;
    repeat (4) @(negedge sys_clk);
    chk("config_ready", 16'h0000, config_ready);
    rst_b = 1'h1;
    por_b = 1'h1;
    for (int i = 0; i < 64; i++)
    begin
      if (p) nv[i] = rst_val({i[5:0], 1'h0});
      mdl[i] = backed({i[5:0], 1'h0}) ? nv[i] : rst_val({i[5:0], 1'h0});
    end
    pend = 1'h0;
    for (int k = 0; k < 20 && config_ready !== 1'h1; k++)
      @(negedge sys_clk);
    chk("config_ready", 16'h0001, config_ready);
  endtask : do_reset
  task automatic op(logic w, logic [6:0] a, logic [7:0] d);
    logic [1:0] m;
    logic [1:0] e;
    for (int k = 0; k < 500 && cmd_ready !== 1'h1; k++)
      @(negedge sys_clk);
    chk("cmd_ready", 16'h0001, cmd_ready);
    chk("sample_index", mdl[13][9:0], sample_index);
    chk("capture_start", e_cap[15:0], n_cap[15:0]);
    chk("flash_store", e_st[15:0], n_st[15:0]);
    for (int i = 0; i < 2; i++)
    begin
      m = mdl[27][2*i +: 2];
      case (m)
        2'h0: e = {1'h1, busy_in};
        2'h1: e = {1'h1, alarm_in};
        2'h2: e = {mdl[25][i], mdl[25][i+8]};
        default: e = 2'h0;
      endcase
      chk("gp_line", e, {gp_line_oe[i], gp_line_out[i] & (m != 2'h3)});
    end
    rs = xs(rs);
    busy_in = rs[0];
    alarm_in = rs[1];
    cmd_valid = 1'h1;
    cmd_write = w;
    cmd_addr = a;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    for (int k = 0; k < 300 && rsp_valid !== 1'h1; k++)
      @(negedge sys_clk);
    chk("rsp_valid", 16'h0001, rsp_valid);
    if (pend) chk("rsp_data", pend_v, rsp_data);
    pend = !w;
    if (!w)
    begin
      pend_v = mdl[a[6:1]];
      if (a inside {[7'h14:7'h19]})
        mdl[13][9:0] = mdl[13][9:0] + 10'h001;
    end
    else if (a == 7'h3F)
    begin
      if (d[3]) e_cap++;
      if (d[4])
      begin
        e_st++;
        mdl[0] = mdl[0] + 16'h0001;
        for (int i = 0; i < 64; i++)
          if (backed({i[5:0], 1'h0})) nv[i] = mdl[i];
      end
    end
    else if (a inside {[7'h02:7'h07], [7'h1A:7'h29], [7'h32:7'h39]})
    begin
      if (a[0]) mdl[a[6:1]][15:8] = d;
      else mdl[a[6:1]][7:0] = d;
    end
  endtask : op
  task automatic put(logic [6:0] a, logic [15:0] v);
    result_we = 1'h1;
    result_addr = a;
    result_data = v;
    @(negedge sys_clk);
    result_we = 1'h0;
    mdl[a[6:1]] = v;
  endtask : put
  task automatic scan(int s);
    for (int a = 0; a < 96; a += s)
      op(1'h0, a[6:0], 8'h00);
    op(1'h1, 7'h01, 8'hFF);
  endtask : scan
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    {cmd_valid, cmd_write, result_we, busy_in, alarm_in} = 5'h00;
    {cmd_addr, cmd_data, result_addr, result_data} = 38'h0;
    gp_line_in = 2'h0;
    {n_fail, check_count, n_cap, e_cap, n_st, e_st} = '0;
    do_reset(1'h1);
    scan(2);
    for (int i = 0; i < 2; i++)
    begin
      gp_line_in[i] = 1'h1;
      e_cap++;
      repeat (8) @(negedge sys_clk);
      gp_line_in[i] = 1'h0;
      op(1'h0, 7'h36, 8'h00);
    end
    rs = xs(rs);
    put(7'h14, rs[15:0]);
    put(7'h0B, rs[31:16]);
    repeat (3) op(1'h0, 7'h14, 8'h00);
    op(1'h0, 7'h1A, 8'h00);
    op(1'h0, 7'h0A, 8'h00);
    op(1'h1, 7'h3F, 8'h08);
    op(1'h1, 7'h32, 8'h02);
    op(1'h1, 7'h33, 8'h01);
    for (int m = 0; m < 4; m++)
      op(1'h1, 7'h36, {4'h0, m[1:0], m[1:0]});
    repeat (24)
    begin
      rs = xs(rs);
      if (rs[6:1] == 6'h1F) rs[1] = 1'h0;
      op(rs[7], rs[6:0], rs[15:8]);
    end
    op(1'h1, 7'h3F, 8'h10);
    rs = xs(rs);
    op(1'h1, 7'h03, rs[7:0]);
    op(1'h0, 7'h02, 8'h00);
    do_reset(1'h0);
    scan(6);
    close_out();
  end
  initial
  begin
    #(40 * 95000);
    n_fail++;
    close_out();
  end
endmodule : ssra_tb_top
